//--- hw/phy_id_autoneg_regs.sv
// Identifier and auto-negotiation register bank with its own
// serial management slave. Assumes the auto-negotiation engine runs
// on mclk and gives one-cycle event pulses; mdc, mdio and straps
// are pins and are synchronised here.
`timescale 1ns/10ps
`include "phy_regs_defs.svh"

module phy_id_autoneg_regs #(
  parameter logic [15:0] IDENT_HI_RST = 16'h1357, // Arbitrary value
  parameter logic [5:0]  OUI_LOW_RST  = 6'h2b,    // Arbitrary value
  parameter logic [5:0]  MODEL_RST    = 6'h15,    // Arbitrary value
  parameter logic [3:0]  REV_RST      = 4'h1      // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output wire logic        mdio_out,
  output wire logic        mdio_oe,
  input  wire logic [4:0]  dev_addr_strap,
  input  wire logic        pause_strap_pin,
  input  wire logic [1:0]  mode_strap,
  input  wire logic        lp_page_valid,
  input  wire logic [15:0] lp_page,
  input  wire logic        lp_an_able,
  input  wire logic        pd_fault_evt,
  input  wire logic        np_sent,
  input  wire logic        an_enable,
  input  wire logic [1:0]  man_speed,
  input  wire logic        man_duplex,
  input  wire logic [1:0]  neg_speed,
  input  wire logic        neg_duplex,
  output wire logic [15:0] adv_word,
  output wire logic [15:0] np_word,
  output wire logic        np_load,
  output wire logic [1:0]  speed_sel,
  output wire logic        full_duplex
);

  // Arbitrary identity values; replace per product
  localparam logic [15:0] IDENT_LO_RST = {OUI_LOW_RST, MODEL_RST, REV_RST};

  localparam phy_regs_pkg::regs_t RST_VAL = '{
    mdc_sync:  3'h0,
    mdio_sync: 2'h0,
    strap_s1:  8'h00,
    strap_s2:  8'h00,
    strap_cnt: 2'h0,
    dev_addr:  5'h00,
    st:        phy_regs_pkg::MD_PRE,
    cnt:       6'h00,
    op:        2'h0,
    sh:        16'h0000,
    regad:     5'h00,
    mdio_out:  1'b0,
    mdio_oe:   1'b0,
    id_hi:     IDENT_HI_RST,
    id_lo:     IDENT_LO_RST,
    adv:       `ADV_RST,
    lpa:       `LPA_RST,
    nptx:      `NPTX_RST,
    tog:       1'b0,
    pd_fault:  1'b0,
    page_rx:   1'b0,
    np_load:   1'b0,
    speed:     2'h0,
    duplex:    1'b0
  };

  logic [1:0]           rst_sync_q;
  logic                 rst_int_n;
  phy_regs_pkg::regs_t  q;
  phy_regs_pkg::regs_t  d;
  logic                 rise;
  logic                 bit_in;
  logic                 rd_clr;
  logic [15:0]          word;
  logic                 hit;

  // Pin reset reaches the logic through two flip-flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync_q[1];

  function automatic logic [3:0] abil_of(input logic [1:0] mode);
    case (mode)
      2'h0:    abil_of = `ABIL_MODE0;
      2'h1:    abil_of = `ABIL_MODE1;
      2'h2:    abil_of = `ABIL_MODE2;
      default: abil_of = `ABIL_MODE3;
    endcase
  endfunction

  // Advertisement as seen from outside; reserved bits read low
  function automatic logic [15:0] adv_view(input logic [15:0] r);
    adv_view                = 16'h0000;
    adv_view[`ADV_NP]       = r[`ADV_NP];
    adv_view[`ADV_RFLT]     = r[`ADV_RFLT];
    adv_view[`ADV_ASYM]     = r[`ADV_ASYM];
    adv_view[`ADV_PAUSE]    = r[`ADV_PAUSE];
    adv_view[`ADV_ABIL_LSB+3:`ADV_ABIL_LSB] = r[`ADV_ABIL_LSB+3:`ADV_ABIL_LSB];
    adv_view[`SEL_MSB:0]    = r[`SEL_MSB:0];
  endfunction

  // Partner base page as read; T4 and reserved bits read low
  function automatic logic [15:0] lpa_view(input logic [15:0] r);
    lpa_view                = 16'h0000;
    lpa_view[`LPA_NP]       = r[`LPA_NP];
    lpa_view[`LPA_ACK]      = r[`LPA_ACK];
    lpa_view[`LPA_RFLT]     = r[`LPA_RFLT];
    lpa_view[`LPA_PAUSE]    = r[`LPA_PAUSE];
    lpa_view[`ADV_ABIL_LSB+3:`ADV_ABIL_LSB] = r[`ADV_ABIL_LSB+3:`ADV_ABIL_LSB];
    lpa_view[`SEL_MSB:0]    = r[`SEL_MSB:0];
  endfunction

  // Next page as read; the toggle comes from its own flop
  function automatic logic [15:0] np_view(input logic [15:0] r, input logic tg);
    np_view                 = 16'h0000;
    np_view[`NPTX_NP]       = r[`NPTX_NP];
    np_view[`NPTX_MP]       = r[`NPTX_MP];
    np_view[`NPTX_ACK2]     = r[`NPTX_ACK2];
    np_view[`NPTX_TOG]      = tg;
    np_view[`NPTX_TOG-1:0]  = r[`NPTX_TOG-1:0];
  endfunction

  // Expansion flags; local next-page ability is absent
  function automatic logic [15:0] exp_view(input phy_regs_pkg::regs_t s,
                                           input logic an_able);
    exp_view                = 16'h0000;
    exp_view[`EXP_PDF]      = s.pd_fault;
    exp_view[`EXP_LPNP]     = s.lpa[`LPA_NP];
    exp_view[`EXP_NP]       = 1'b0;
    exp_view[`EXP_PR]       = s.page_rx;
    exp_view[`EXP_LPAN]     = an_able;
  endfunction

  function automatic logic [15:0] rd_word(input phy_regs_pkg::regs_t s,
                                          input logic [4:0] ra,
                                          input logic an_able);
    case (ra)
      `REG_ID_HI: begin
        rd_word = s.id_hi;
      end
      `REG_ID_LO: begin
        rd_word = s.id_lo;
      end
      `REG_ADV: begin
        rd_word = adv_view(s.adv);
      end
      `REG_LPA: begin
        rd_word = lpa_view(s.lpa);
      end
      `REG_EXP: begin
        rd_word = exp_view(s, an_able);
      end
      `REG_NPTX: begin
        rd_word = np_view(s.nptx, s.tog);
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  endfunction

  always_comb begin
    d = q;
    rd_clr = 1'b0;
    word = {q.sh[14:0], q.mdio_sync[1]};
    hit = 1'b0;
    d.mdc_sync = {q.mdc_sync[1:0], mdc};
    d.mdio_sync = {q.mdio_sync[0], mdio_in};
    d.strap_s1 = {dev_addr_strap, pause_strap_pin, mode_strap};
    d.strap_s2 = q.strap_s1;
    d.np_load = 1'b0;
    rise = q.mdc_sync[1] & ~q.mdc_sync[2];
    bit_in = q.mdio_sync[1];

    // Straps are caught once their synchronised copy has settled
    if (q.strap_cnt != 2'h3) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
    end
    if (q.strap_cnt == `STRAP_WAIT) begin
      d.dev_addr = q.strap_s2[7:3];
      d.adv[`ADV_PAUSE] = q.strap_s2[2];
      d.adv[`ADV_ABIL_LSB+3:`ADV_ABIL_LSB] = abil_of(q.strap_s2[1:0]);
    end

    if (rise) begin
      case (q.st)
        // Count ones; a zero after a full preamble starts a frame
        phy_regs_pkg::MD_PRE: begin
          if (bit_in) begin
            if (q.cnt != `PRE_LEN) begin
              d.cnt = q.cnt + 6'h01;
            end
          end else begin
            if (q.cnt == `PRE_LEN) begin
              d.st = phy_regs_pkg::MD_ST;
            end
            d.cnt = 6'h00;
          end
        end
        // Second start bit must be one
        phy_regs_pkg::MD_ST: begin
          d.cnt = 6'h00;
          d.st = bit_in ? phy_regs_pkg::MD_OP : phy_regs_pkg::MD_PRE;
        end
        // Two opcode bits; anything but read or write is dropped
        phy_regs_pkg::MD_OP: begin
          d.sh = word;
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == `OP_BITS) begin
            d.op = word[1:0];
            d.cnt = 6'h00;
            if (word[1:0] == `OP_RD || word[1:0] == `OP_WR) begin
              d.st = phy_regs_pkg::MD_ADR;
            end else begin
              d.st = phy_regs_pkg::MD_PRE;
            end
          end
        end
        // Device and register address; read data is fetched here
        phy_regs_pkg::MD_ADR: begin
          d.sh = word;
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == `ADR_BITS) begin
            d.cnt = 6'h00;
            d.regad = word[4:0];
            hit = (word[9:5] == q.dev_addr) &&
                  (word[4:0] >= `REG_ID_HI) && (word[4:0] <= `REG_NPTX);
            // Other device or index: never drive, hunt for preamble
            if (!hit) begin
              d.st = phy_regs_pkg::MD_PRE;
            end else begin
              d.st = phy_regs_pkg::MD_TA;
              if (q.op == `OP_RD) begin
                d.sh = rd_word(q, word[4:0], lp_an_able);
                rd_clr = (word[4:0] == `REG_EXP);
              end
            end
          end
        end
        // Read drives the second turnaround bit low
        phy_regs_pkg::MD_TA: begin
          if (q.op == `OP_RD) begin
            d.mdio_oe = 1'b1;
            d.mdio_out = 1'b0;
            d.st = phy_regs_pkg::MD_RD;
          end else if (q.cnt == `TA_BITS) begin
            d.cnt = 6'h00;
            d.st = phy_regs_pkg::MD_WR;
          end else begin
            d.cnt = q.cnt + 6'h01;
          end
        end
        // Shift read data out MSB first, then release the line
        phy_regs_pkg::MD_RD: begin
          if (q.cnt == `RD_BITS) begin
            d.mdio_oe = 1'b0;
            d.mdio_out = 1'b0;
            d.cnt = 6'h00;
            d.st = phy_regs_pkg::MD_PRE;
          end else begin
            d.mdio_out = q.sh[15];
            d.sh = {q.sh[14:0], 1'b0};
            d.cnt = q.cnt + 6'h01;
          end
        end
        // Collect sixteen data bits; read-only indices drop them
        phy_regs_pkg::MD_WR: begin
          d.sh = word;
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == `DATA_BITS) begin
            d.cnt = 6'h00;
            d.st = phy_regs_pkg::MD_PRE;
            case (q.regad)
              `REG_ID_HI: begin
                d.id_hi = word;
              end
              `REG_ID_LO: begin
                d.id_lo = word;
              end
              `REG_ADV: begin
                d.adv = word & `ADV_WMASK;
              end
              `REG_NPTX: begin
                d.nptx = word & `NPTX_WMASK;
                d.np_load = 1'b1;
              end
              default: d.sh = word;
            endcase
          end
        end
        default: begin
          d.st = phy_regs_pkg::MD_PRE;
          d.cnt = 6'h00;
          d.mdio_oe = 1'b0;
        end
      endcase
    end

    // Engine strobes take effect on the next cycle
    if (lp_page_valid) begin
      d.lpa = lp_page & `LPA_MASK;
    end
    if (np_sent) begin
      d.tog = ~q.tog;
    end
    // Set beats a read that clears in the same cycle
    d.pd_fault = (q.pd_fault & ~rd_clr) | pd_fault_evt;
    d.page_rx = (q.page_rx & ~rd_clr) | lp_page_valid;

    // Negotiated result overrides the manual settings while enabled
    d.speed = an_enable ? neg_speed : man_speed;
    d.duplex = an_enable ? neg_duplex : man_duplex;
  end

  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  // Engine-facing words use the same views as management reads
  assign mdio_out    = q.mdio_out;
  assign mdio_oe     = q.mdio_oe;
  assign adv_word    = adv_view(q.adv);
  assign np_word     = np_view(q.nptx, q.tog);
  assign np_load     = q.np_load;
  assign speed_sel   = q.speed;
  assign full_duplex = q.duplex;

endmodule // phy_id_autoneg_regs

//--- hw/phy_regs_defs.svh
// Offsets, field positions, reset values and timing counts of the
// identifier and auto-negotiation register bank. Assumes a serial
// management frame with 5-bit device and register addresses.
//
// Operation
// - First identifier register holds OUI bits 3 to 18 across all 16 bits
// - Second identifier bits 15:10 hold OUI bits 19 to 24
// - Second identifier bits 9:4 hold the six-bit model number
// - Second identifier bits 3:0 hold revision, reset per silicon revision
// - Advertisement and partner selector fields reset to 00001, IEEE 802.3
// - Advertisement next-page bit writable, resets 0, no next-page exchange done
// - Advertisement pause bit resets from the pause strap pin
// - Advertisement asymmetric pause bit writable, resets 0
// - Four advertised ability bits reset from the mode strap pins
// - Partner ability register read-only, mirrors received base page, resets to 00001
// - Partner T4 ability bit read-only, always 0
// - Expansion latches parallel detection fault
// - Expansion latches page-received when a partner page arrives
// - Read-only expansion bit shows partner next-page ability
// - Read-only expansion bit shows local next-page ability, always 0
// - Read-only expansion bit shows partner auto-negotiation ability
// - Next-page message-page bit resets 1, acknowledge-2 resets 0, both writable
// - Next-page toggle read-only, opposite of previous toggle value
// - Next-page eleven-bit code field writable, resets to one
// - With auto-negotiation enabled negotiated speed and duplex override manual
`ifndef PHY_REGS_DEFS_SVH
`define PHY_REGS_DEFS_SVH

`define REG_ID_HI    5'h02
`define REG_ID_LO    5'h03
`define REG_ADV      5'h04
`define REG_LPA      5'h05
`define REG_EXP      5'h06
`define REG_NPTX     5'h07

`define SEL_8023     5'h01
`define ADV_RST      16'h0001
`define ADV_WMASK    16'hadff
`define ADV_NP       15
`define ADV_ASYM     11
`define ADV_PAUSE    10
`define ADV_ABIL_LSB 5
`define LPA_RST      16'h0001
`define LPA_MASK     16'he5ff
`define LPA_NP       15
`define NPTX_RST     16'h2001
`define NPTX_WMASK   16'hb7ff
`define NPTX_TOG     11
`define ADV_RFLT     13
`define SEL_MSB      4
`define LPA_ACK      14
`define LPA_RFLT     13
`define LPA_PAUSE    10
`define NPTX_NP      15
`define NPTX_MP      13
`define NPTX_ACK2    12
`define EXP_PDF      4
`define EXP_LPNP     3
`define EXP_NP       2
`define EXP_PR       1
`define EXP_LPAN     0

`define ABIL_MODE0   4'h1
`define ABIL_MODE1   4'h3
`define ABIL_MODE2   4'h7
`define ABIL_MODE3   4'hf

`define PRE_LEN      6'h20
`define OP_RD        2'h2
`define OP_WR        2'h1
`define ADR_BITS     6'h09
`define DATA_BITS    6'h0f
`define OP_BITS      6'h01
`define TA_BITS      6'h01
`define RD_BITS      6'h10
`define STRAP_WAIT   2'h2

`endif

//--- hw/phy_regs_pkg.sv
// Types of the identifier and auto-negotiation register bank.
// Assumes nothing beyond the constants header.
package phy_regs_pkg;

  typedef enum logic [2:0] {
    MD_PRE,
    MD_ST,
    MD_OP,
    MD_ADR,
    MD_TA,
    MD_RD,
    MD_WR
  } mdio_st_t;

  typedef struct packed {
    logic [2:0]  mdc_sync;
    logic [1:0]  mdio_sync;
    logic [7:0]  strap_s1;
    logic [7:0]  strap_s2;
    logic [1:0]  strap_cnt;
    logic [4:0]  dev_addr;
    mdio_st_t    st;
    logic [5:0]  cnt;
    logic [1:0]  op;
    logic [15:0] sh;
    logic [4:0]  regad;
    logic        mdio_out;
    logic        mdio_oe;
    logic [15:0] id_hi;
    logic [15:0] id_lo;
    logic [15:0] adv;
    logic [15:0] lpa;
    logic [15:0] nptx;
    logic        tog;
    logic        pd_fault;
    logic        page_rx;
    logic        np_load;
    logic [1:0]  speed;
    logic        duplex;
  } regs_t;

endpackage

//--- tb/phy_regs_asserts.sv
// Port checker of the identifier and auto-negotiation register bank.
// Sees only the top ports; bound to the design at the foot of this file.
`timescale 1ns/10ps
module phy_regs_asserts (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        mdio_oe,
  input wire logic        np_sent,
  input wire logic        np_load,
  input wire logic        an_enable,
  input wire logic [1:0]  man_speed,
  input wire logic        man_duplex,
  input wire logic [1:0]  neg_speed,
  input wire logic        neg_duplex,
  input wire logic [1:0]  speed_sel,
  input wire logic        full_duplex,
  input wire logic [15:0] adv_word,
  input wire logic [15:0] np_word
);
  logic [2:0] up_q;

  // Cycles since reset release, saturating; spans the internal sync delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_speed_resolve: assert property (up_q == 3'h7 |->
    speed_sel == ($past(an_enable) ? $past(neg_speed) : $past(man_speed)))
    else $error("speed select wrong");
  a_duplex_resolve: assert property (up_q == 3'h7 && an_enable |=>
    full_duplex == $past(neg_duplex)) else $error("duplex wrong");
  a_adv_reserved: assert property ((adv_word & 16'h5200) == 16'h0000)
    else $error("adv reserved set");
  a_np_reserved: assert property (np_word[14] == 1'b0)
    else $error("np reserved set");
  a_toggle_flip: assert property (np_sent && up_q == 3'h7 |=>
    np_word[11] != $past(np_word[11])) else $error("toggle not flipped");
  a_toggle_hold: assert property (!np_sent && up_q == 3'h7 |=>
    $stable(np_word[11])) else $error("toggle moved");
  a_sel_reset: assert property (up_q != 3'h7 |-> adv_word[4:0] == 5'h01)
    else $error("selector reset wrong");
  a_np_reset: assert property (up_q != 3'h7 |-> np_word == 16'h2001)
    else $error("next page reset wrong");
  a_adv_np_reset: assert property (up_q == 3'h1 |-> !adv_word[15] [*4])
    else $error("adv next page set");
  a_asym_reset: assert property (up_q != 3'h7 |-> !adv_word[11])
    else $error("asym pause set");

  cover property (np_sent);
  cover property ($rose(mdio_oe));
  cover property (np_load);
endmodule // phy_regs_asserts

bind phy_id_autoneg_regs phy_regs_asserts u_chk (.mclk, .rst_n, .mdio_oe, .np_sent,
  .np_load, .an_enable, .man_speed, .man_duplex, .neg_speed, .neg_duplex, .speed_sel,
  .full_duplex, .adv_word, .np_word);

//--- tb/mdio_station.sv
// Station manager model: runs management frames on mdc and mdio.
// Assumes a pull-up on mdio; mdc stands low between frames.
`timescale 1ns/10ps
module mdio_station (
  input  wire logic mclk,
  output logic      mdc,
  output wire logic mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic drv;
  logic drv_en;

  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_en = 1'b0;
  end

  // Bits change in the low phase; read data sampled two cycles after mdc falls, before the next bit is driven
  task automatic xfer(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, (wr ? 2'b01 : 2'b10), pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(negedge mclk);
      drv_en = wr || i < 46;
      drv = f[63 - i];
      repeat (2) @(negedge mclk);
      mdc = 1'b1;
      repeat (4) @(negedge mclk);
      mdc = 1'b0;
      repeat (2) @(negedge mclk);
      if (i > 46 && i < 63)
        rd[62 - i] = mdio_in;
    end
    drv_en = 1'b0;
  endtask
endmodule // mdio_station

//--- tb/phy_id_autoneg_regs_tb.sv
// Testbench of the identifier and auto-negotiation register bank.
// Registers reached by management frames from the station model.
`timescale 1ns/10ps
module phy_id_autoneg_regs_tb;
  logic        mclk, rst_n, mdc, mdio_in, mdio_out, mdio_oe, np_load, full_duplex;
  logic        pause_strap_pin, lp_page_valid, lp_an_able, pd_fault_evt, np_sent;
  logic        an_enable, man_duplex, neg_duplex;
  logic [1:0]  mode_strap, man_speed, neg_speed, speed_sel;
  logic [15:0] lp_page, adv_word, np_word, d;
  int          miscompares, num_checks, cyc, loads;
  localparam logic [3:0] ABIL [4] = '{4'h1, 4'h3, 4'h7, 4'hf};

  // Identity parameter values are arbitrary
  phy_id_autoneg_regs #(.IDENT_HI_RST(16'h2468), .OUI_LOW_RST(6'h11),
    .MODEL_RST(6'h22), .REV_RST(4'h3)) u_dut (.mclk, .rst_n, .mdc, .mdio_in,
    .mdio_out, .mdio_oe, .dev_addr_strap(5'h0a), .pause_strap_pin, .mode_strap,
    .lp_page_valid, .lp_page, .lp_an_able, .pd_fault_evt, .np_sent, .an_enable,
    .man_speed, .man_duplex, .neg_speed, .neg_duplex, .adv_word, .np_word,
    .np_load, .speed_sel, .full_duplex);
  mdio_station u_mgr (.mclk, .mdc, .mdio_in, .mdio_out, .mdio_oe);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      print_verdict();
    end
  end

  // Counts next-page load pulses seen by the engine side
  always @(posedge mclk) begin
    if (np_load === 1'b1)
      loads++;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] q;
    u_mgr.xfer(1'b0, 5'h0a, ra, 16'h0000, q);
    cmp(q, exp);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] v);
    u_mgr.xfer(1'b1, 5'h0a, ra, v, d);
  endtask

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask

  initial begin
    {rst_n, pause_strap_pin, lp_page_valid, lp_an_able, pd_fault_evt, np_sent} = 6'h00;
    {an_enable, man_duplex, neg_duplex, mode_strap, man_speed, neg_speed} = 9'h000;
    lp_page = 16'h0000;
    for (int m = 0; m < 4; m++) begin
      @(negedge mclk);
      rst_n = 1'b0;
      mode_strap = m[1:0];
      pause_strap_pin = m[0];
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      repeat (12) @(negedge mclk);
      rdc(5'h04, {5'h00, m[0], 1'b0, ABIL[m], 5'h01});
      cmp(adv_word, {5'h00, m[0], 1'b0, ABIL[m], 5'h01});
    end
    rdc(5'h02, 16'h2468);
    rdc(5'h03, {6'h11, 6'h22, 4'h3});
    rdc(5'h05, 16'h0001);
    rdc(5'h06, 16'h0000);
    rdc(5'h07, 16'h2001);
    u_mgr.xfer(1'b0, 5'h0b, 5'h02, 16'h0000, d);
    cmp(d, 16'hffff);
    u_mgr.xfer(1'b0, 5'h0a, 5'h08, 16'h0000, d);
    cmp(d, 16'hffff);
    $display("reset values done");
    wr(5'h04, 16'hffff);
    rdc(5'h04, 16'hadff);
    wr(5'h05, 16'h1234);
    wr(5'h06, 16'hffff);
    rdc(5'h05, 16'h0001);
    lp_page = 16'hffff;
    lp_an_able = 1'b1;
    pulse(lp_page_valid);
    rdc(5'h05, 16'he5ff);
    rdc(5'h06, 16'h000b);
    rdc(5'h06, 16'h0009);
    pulse(pd_fault_evt);
    rdc(5'h06, 16'h0019);
    $display("partner and expansion done");
    wr(5'h07, 16'hffff);
    cmp(np_word, 16'hb7ff);
    cmp(loads[15:0], 16'h0001);
    pulse(np_sent);
    rdc(5'h07, 16'hbfff);
    {an_enable, neg_speed, neg_duplex, man_speed, man_duplex} = 7'h55;
    repeat (2) @(negedge mclk);
    cmp({13'h0000, speed_sel, full_duplex}, 16'h0002);
    an_enable = 1'b0;
    repeat (2) @(negedge mclk);
    cmp({13'h0000, speed_sel, full_duplex}, 16'h0005);
    $display("next page and speed done");
    print_verdict();
  end
endmodule // phy_id_autoneg_regs_tb
